// file: twi_pkg.sv
// constants, codes and states of the two-wire slave block
// What this block does
// - general call data NACKed reports 0x98
// - general call data ACKed reports 0x90
// - STOP or repeated START while addressed: 0xA0
// - begin request sends START once bus free
// - back in idle, own and enabled GC recognised
// - seven-bit address upper bits, GC by LSB
// - read bit enters transmit, else receive
// - address matched sets flag with valid code
// - lost arbitration then read reports 0xB0
// - ack enable cleared: last byte, 0xC0/0xC8
// - after last byte ignore master, release data
// - ack enable low isolates, bus still watched
// - in sleep still acknowledge matching address
// - sleep match wakes, holds clock until cleared
// - data register not updated during sleep
// - own address data NACKed reports 0x88
package twi_pkg;
	localparam logic [7:0] ADDR_OWN   = 8'h00;
	localparam logic [7:0] ADDR_CTRL  = 8'h04;
	localparam logic [7:0] ADDR_STAT  = 8'h08;
	localparam logic [7:0] ADDR_DATA  = 8'h0C;
	localparam logic [7:0] ADDR_ISTAT = 8'h10;
	localparam logic [7:0] ADDR_ICLR  = 8'h14;
	localparam logic [7:0] ADDR_IEN   = 8'h18;
	localparam logic [2:0] R_OWN = 3'h0, R_CTRL = 3'h1, R_STAT = 3'h2, R_DATA = 3'h3;
	localparam logic [2:0] R_ISTAT = 3'h4, R_ICLR = 3'h5, R_IEN = 3'h6, R_NONE = 3'h7;
	localparam int B_INT = 7, B_EA = 6, B_STA = 5, B_STO = 4, B_WC = 3, B_EN = 2, B_IE = 0;
	localparam int EV_FLAG = 0, EV_STOP = 1, EV_WAKE = 2, EV_W = 3;
	localparam logic [7:0] OWN_RESET  = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [7:0] SR_ADDR = 8'h60, SR_ADDR_AL = 8'h68, SR_GC = 8'h70, SR_GC_AL = 8'h78;
	localparam logic [7:0] SR_DATA_ACK = 8'h80, SR_DATA_NACK = 8'h88;
	localparam logic [7:0] SR_GC_ACK = 8'h90, SR_GC_NACK = 8'h98, SR_STOP = 8'hA0;
	localparam logic [7:0] ST_ADDR = 8'hA8, ST_ADDR_AL = 8'hB0, ST_ACK = 8'hB8;
	localparam logic [7:0] ST_NACK = 8'hC0, ST_LAST = 8'hC8, NO_INFO = 8'hF8;
	localparam logic [2:0] CNT_LAST = 3'h7;
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_START_NS = 4000;
	localparam int START_CYC = (T_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] START_LAST = 8'(START_CYC - 1);
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_HOLD} st_t;
endpackage : twi_pkg

// file: two_wire_slave.sv
// slave receive/transmit engine of the two-wire interface with APB registers
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave
	import twi_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// bus pins, open drain
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// system side
	input  wire logic        sleep_mode,
	input  wire logic        lost_arb,
	output logic             wake_req,
	output logic             irq
);
	function automatic logic [2:0] dec(input logic [7:0] a);
		if (a == ADDR_OWN) dec = R_OWN;
		else if (a == ADDR_CTRL) dec = R_CTRL;
		else if (a == ADDR_STAT) dec = R_STAT;
		else if (a == ADDR_DATA) dec = R_DATA;
		else if (a == ADDR_ISTAT) dec = R_ISTAT;
		else if (a == ADDR_ICLR) dec = R_ICLR;
		else if (a == ADDR_IEN) dec = R_IEN;
		else dec = R_NONE;
	endfunction : dec

	// pin synchronisers
	logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			scl_meta <= 1'b1;
			scl_s    <= 1'b1;
			scl_d    <= 1'b1;
			sda_meta <= 1'b1;
			sda_s    <= 1'b1;
			sda_d    <= 1'b1;
		end
		else
		begin
			scl_meta <= scl_in;
			scl_s    <= scl_meta;
			scl_d    <= scl_s;
			sda_meta <= sda_in;
			sda_s    <= sda_meta;
			sda_d    <= sda_s;
		end
	end

	logic rise, fall, start_det, stop_det;
	assign rise      = scl_s & ~scl_d;
	assign fall      = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

	st_t         state, next_state, after_st, next_after_st;
	logic [2:0]  cnt, next_cnt;
	logic [7:0]  shreg, next_shreg, code, next_code, own, next_own, data, next_data;
	logic [7:0]  gen_cnt, next_gen_cnt;
	logic [EV_W-1:0] istat, next_istat, ien, next_ien;
	logic [31:0] next_prdata;
	logic irq_flag, next_irq_flag, ea, next_ea, sta, next_sta, sto, next_sto;
	logic wc, next_wc, en, next_en, ie, next_ie;
	logic selected, next_selected, gc, next_gc, slot, next_slot, ack_now, next_ack_now;
	logic tx_last, next_tx_last, sda_drv, next_sda_drv, start_pend, next_start_pend;
	logic bus_free, next_bus_free, gen_act, next_gen_act, wake, next_wake;

	logic       wr, rd_setup, hit, m_own, m_gc, clr_flag, sta_after;
	logic [2:0] wsel;
	logic [7:0] nb, ctrl_rd;
	logic [EV_W-1:0] ev;

	assign ctrl_rd = {irq_flag, ea, sta, sto, wc, en, 1'b0, ie};
	assign wsel    = dec(paddr);
	assign wr      = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign nb      = {shreg[6:0], sda_s};
	assign m_own   = nb[7:1] == own[7:1];
	assign m_gc    = (nb[7:1] == GEN_CALL_ADDR) & own[0];
	// ack enable gates recognition; bus is still sampled while isolated
	assign hit     = en & ea & (m_own | m_gc);

	always_comb
	begin
		next_state = state;
		next_after_st = after_st;
		next_cnt = cnt;
		next_shreg = shreg;
		next_code = code;
		next_own = own;
		next_data = data;
		next_gen_cnt = gen_cnt;
		next_irq_flag = irq_flag;
		next_ea = ea;
		next_sta = sta;
		next_sto = sto;
		next_wc = wc;
		next_en = en;
		next_ie = ie;
		next_ien = ien;
		next_selected = selected;
		next_gc = gc;
		next_slot = slot;
		next_ack_now = ack_now;
		next_tx_last = tx_last;
		next_sda_drv = sda_drv;
		next_start_pend = start_pend;
		next_bus_free = bus_free;
		next_gen_act = gen_act;
		next_wake = wake;
		next_prdata = prdata;
		clr_flag = 1'b0;
		sta_after = sta;
		ev = '0;
		// register writes take effect in the access phase
		if (wr)
		begin
			if (wsel == R_OWN) next_own = pwdata[7:0];
			else if (wsel == R_CTRL)
			begin
				next_ea = pwdata[B_EA];
				next_sta = pwdata[B_STA];
				next_sto = pwdata[B_STO];
				next_en = pwdata[B_EN];
				next_ie = pwdata[B_IE];
				clr_flag = pwdata[B_INT];
				sta_after = pwdata[B_STA];
			end
			else if (wsel == R_DATA)
			begin
				if (irq_flag) next_data = pwdata[7:0];
				next_wc = ~irq_flag;
			end
			else if (wsel == R_IEN) next_ien = pwdata[EV_W-1:0];
		end
		if (clr_flag)
		begin
			next_irq_flag = 1'b0;
			next_wake = 1'b0;
			// leaving a slave state for unaddressed mode with begin set
			if (sta_after && (state == S_IDLE || (state == S_HOLD && after_st == S_IDLE)))
				next_start_pend = 1'b1;
		end
		if (stop_det) next_bus_free = 1'b1;
		if (start_det) next_bus_free = 1'b0;
		case (state)
			S_ADDR: if (rise)
			begin
				next_shreg = nb;
				next_cnt = cnt + 3'h1;
				if (cnt == CNT_LAST)
				begin
					next_state = hit ? S_ADDR_ACK : S_IDLE;
					next_gc = ~m_own;
				end
			end
			S_ADDR_ACK: if (fall)
			begin
				next_slot = ~slot;
				next_sda_drv = ~slot;
				if (slot)
				begin
					next_irq_flag = 1'b1;
					ev[EV_FLAG] = 1'b1;
					next_selected = 1'b1;
					next_state = S_HOLD;
					next_after_st = shreg[0] ? S_TX : S_RX;
					if (sleep_mode)
					begin
						next_wake = 1'b1;
						ev[EV_WAKE] = 1'b1;
					end
					if (shreg[0]) next_code = lost_arb ? ST_ADDR_AL : ST_ADDR;
					else if (gc) next_code = lost_arb ? SR_GC_AL : SR_GC;
					else next_code = lost_arb ? SR_ADDR_AL : SR_ADDR;
				end
			end
			S_RX: if (rise)
			begin
				next_shreg = nb;
				next_cnt = cnt + 3'h1;
				if (cnt == CNT_LAST)
				begin
					next_state = S_RX_ACK;
					next_ack_now = ea;
				end
			end
			S_RX_ACK: if (fall)
			begin
				next_slot = ~slot;
				next_sda_drv = ~slot & ack_now;
				if (slot)
				begin
					next_irq_flag = 1'b1;
					ev[EV_FLAG] = 1'b1;
					// in sleep mode the byte register is left as it was
					if (!sleep_mode) next_data = shreg;
					next_state = S_HOLD;
					next_after_st = ack_now ? S_RX : S_IDLE;
					if (gc) next_code = ack_now ? SR_GC_ACK : SR_GC_NACK;
					else next_code = ack_now ? SR_DATA_ACK : SR_DATA_NACK;
				end
			end
			S_TX: if (fall)
			begin
				next_cnt = cnt + 3'h1;
				next_shreg = {shreg[6:0], 1'b1};
				next_sda_drv = ~shreg[6];
				if (cnt == CNT_LAST)
				begin
					next_state = S_TX_ACK;
					next_sda_drv = 1'b0;
				end
			end
			S_TX_ACK:
			begin
				if (rise)
				begin
					next_ack_now = ~sda_s;
					if (sda_s) next_code = ST_NACK;
					else next_code = tx_last ? ST_LAST : ST_ACK;
				end
				if (fall)
				begin
					next_irq_flag = 1'b1;
					ev[EV_FLAG] = 1'b1;
					next_state = S_HOLD;
					// after the last byte the master only clocks in ones
					next_after_st = (ack_now && !tx_last) ? S_TX : S_IDLE;
				end
			end
			S_HOLD: if (!irq_flag)
			begin
				next_state = after_st;
				next_cnt = '0;
				if (after_st == S_IDLE) next_selected = 1'b0;
				if (after_st == S_TX)
				begin
					next_shreg = data;
					next_sda_drv = ~data[7];
					next_tx_last = ~ea;
				end
			end
			default: ;
		endcase
		// a START restarts address reception, a STOP ends everything
		if (start_det || stop_det)
		begin
			if (selected)
			begin
				next_code = SR_STOP;
				next_irq_flag = 1'b1;
				ev[EV_STOP] = 1'b1;
				ev[EV_FLAG] = 1'b1;
			end
			next_selected = 1'b0;
			next_state = start_det ? S_ADDR : S_IDLE;
			next_after_st = S_IDLE;
			next_cnt = '0;
			next_slot = 1'b0;
			next_sda_drv = 1'b0;
		end
		// own START generation once the bus is free
		if (gen_act)
		begin
			next_gen_cnt = gen_cnt + 8'h01;
			if (gen_cnt == START_LAST)
			begin
				next_gen_act = 1'b0;
				next_start_pend = 1'b0;
				next_sta = 1'b0;
			end
		end
		else if (start_pend && bus_free && state == S_IDLE)
		begin
			next_gen_act = 1'b1;
			next_gen_cnt = '0;
		end
		next_istat = (istat & ~((wr && wsel == R_ICLR) ? pwdata[EV_W-1:0] : '0)) | ev;
		if (rd_setup)
		begin
			next_prdata = '0;
			if (wsel == R_OWN) next_prdata[7:0] = own;
			else if (wsel == R_CTRL) next_prdata[7:0] = ctrl_rd;
			else if (wsel == R_STAT) next_prdata[7:0] = irq_flag ? code : NO_INFO;
			else if (wsel == R_DATA) next_prdata[7:0] = data;
			else if (wsel == R_ISTAT) next_prdata[EV_W-1:0] = istat;
			else if (wsel == R_IEN) next_prdata[EV_W-1:0] = ien;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state <= S_IDLE;
			after_st <= S_IDLE;
			cnt <= '0;
			shreg <= '0;
			code <= NO_INFO;
			own <= OWN_RESET;
			data <= DATA_RESET;
			gen_cnt <= '0;
			istat <= '0;
			ien <= '0;
			prdata <= '0;
			irq_flag <= 1'b0;
			ea <= 1'b0;
			sta <= 1'b0;
			sto <= 1'b0;
			wc <= 1'b0;
			en <= 1'b0;
			ie <= 1'b0;
			selected <= 1'b0;
			gc <= 1'b0;
			slot <= 1'b0;
			ack_now <= 1'b0;
			tx_last <= 1'b0;
			sda_drv <= 1'b0;
			start_pend <= 1'b0;
			bus_free <= 1'b1;
			gen_act <= 1'b0;
			wake <= 1'b0;
		end
		else
		begin
			state <= next_state;
			after_st <= next_after_st;
			cnt <= next_cnt;
			shreg <= next_shreg;
			code <= next_code;
			own <= next_own;
			data <= next_data;
			gen_cnt <= next_gen_cnt;
			istat <= next_istat;
			ien <= next_ien;
			prdata <= next_prdata;
			irq_flag <= next_irq_flag;
			ea <= next_ea;
			sta <= next_sta;
			sto <= next_sto;
			wc <= next_wc;
			en <= next_en;
			ie <= next_ie;
			selected <= next_selected;
			gc <= next_gc;
			slot <= next_slot;
			ack_now <= next_ack_now;
			tx_last <= next_tx_last;
			sda_drv <= next_sda_drv;
			start_pend <= next_start_pend;
			bus_free <= next_bus_free;
			gen_act <= next_gen_act;
			wake <= next_wake;
		end
	end

	// open drain: only ever pull low, never drive high
	assign scl_out  = 1'b0;
	assign sda_out  = 1'b0;
	assign scl_oe   = (state == S_HOLD) & irq_flag;
	assign sda_oe   = sda_drv | gen_act;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & (wsel == R_NONE);
	assign wake_req = wake;
	assign irq      = (|(istat & ien)) | (irq_flag & ie);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_scl_hold: assert property ($rose(wake) |-> scl_oe && irq_flag)
		else $error("clock not held on wake");
	a_scl_only_hold: assert property (scl_oe |-> state == S_HOLD && scl_out == 1'b0)
		else $error("clock pulled outside hold");
	a_stop_code: assert property (stop_det && selected |=> irq_flag && code == SR_STOP)
		else $error("stop while addressed not reported");
	a_gc_nack_idle: assert property (state == S_HOLD && code == SR_GC_NACK && irq_flag ##1 !irq_flag
		|=> state == S_IDLE && !selected)
		else $error("general call nack did not go unaddressed");
	a_isolate: assert property (state == S_ADDR && rise && cnt == CNT_LAST && !ea
		|=> state == S_IDLE)
		else $error("address taken while ack disabled");
	a_dir_tx: assert property (code == ST_ADDR && irq_flag && state == S_HOLD |-> after_st == S_TX)
		else $error("read address not heading to transmit");
	a_last_byte: assert property (state == S_TX_ACK && rise && tx_last && !sda_s
		|=> code == ST_LAST)
		else $error("ack after last byte not reported");
	a_tx_release: assert property (state == S_IDLE |-> !sda_drv)
		else $error("data line driven while unaddressed");
	a_start_gen: assert property (start_pend && bus_free && state == S_IDLE && !gen_act
		&& !start_det && !stop_det |=> gen_act ##1 sda_oe)
		else $error("pending start not generated");
	a_gc_ack: assert property (state == S_RX_ACK && fall && slot && ack_now && gc && !start_det && !stop_det
		|=> code == SR_GC_ACK && irq_flag)
		else $error("general call data ack code wrong");
	a_flag_set: assert property (state == S_ADDR_ACK && fall && slot && !start_det && !stop_det
		|=> irq_flag && selected)
		else $error("flag not set after address");

	c_last: cover property (irq_flag && code == ST_LAST);
	c_stop: cover property (irq_flag && code == SR_STOP);
	c_wake: cover property (wake && scl_oe);
	c_gc_rx: cover property (irq_flag && code == SR_GC_ACK);
endmodule : two_wire_slave
`default_nettype wire

// file: twi_master_model.sv
// behavioural two-wire bus master with open-drain line drive
`timescale 1ns/1ps
`default_nettype none
module twi_master_model (
	// wired bus levels
	input  wire logic scl,
	input  wire logic sda,
	// open-drain pulls, high pulls the line low
	output logic      scl_low,
	output logic      sda_low,
	// stretch waits that ran out
	output int        stuck
);
	localparam int HALF = 200;

	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		stuck = 0;
	end

	// the slave may hold scl low, so wait for the real rise
	task automatic clk_hi();
		int n;
		scl_low = 1'b0;
		for (n = 0; n < 5000 && scl !== 1'b1; n++)
			#10;
		if (scl !== 1'b1)
			stuck++;
		#HALF;
	endtask : clk_hi

	// odd offset keeps line changes away from system clock edges
	task automatic start();
		#3.3;
		sda_low = 1'b0;
		#HALF;
		clk_hi();
		sda_low = 1'b1;
		#HALF;
		scl_low = 1'b1;
	endtask : start

	task automatic stop();
		#3.3;
		sda_low = 1'b1;
		#HALF;
		clk_hi();
		sda_low = 1'b0;
		#HALF;
	endtask : stop

	// byte plus ack slot, msb first; a one releases sda
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
		logic [8:0] o;
		logic [8:0] r;
		#3.3;
		o = {tx, ack_in};
		for (int i = 8; i >= 0; i--)
		begin
			sda_low = !o[i];
			#HALF;
			clk_hi();
			r[i] = sda;
			scl_low = 1'b1;
		end
		{rx, ack} = r;
	endtask : xfer
endmodule : twi_master_model
`default_nettype wire

// file: tb_two_wire_slave.sv
// self-checking bench for the two-wire slave with a bus master model
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_slave;
	import twi_pkg::*;
	logic        clk_sys, rst, psel, penable, pwrite, sleep_mode, lost_arb;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready, pslverr, err, scl_out, scl_oe, sda_out, sda_oe, wake_req, irq;
	logic        scl_low, sda_low, ack;
	logic [7:0]  rx;
	int          bad_count, samples_checked, stuck, n;
	// wired-and with pull-ups: released lines read high
	wire logic   scl = !(scl_low | scl_oe);
	wire logic   sda = !(sda_low | sda_oe);

	two_wire_slave u_two_wire_slave (
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.sleep_mode(sleep_mode), .lost_arb(lost_arb), .wake_req(wake_req), .irq(irq)
	);
	twi_master_model u_twi_master_model (
		.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low), .stuck(stuck)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever
			#25 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			bad_count++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// negedge wait lets register updates land before outputs are looked at
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		@(negedge clk_sys);
	endtask : wr

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask : rdc

	task automatic flag_is(input logic [7:0] code);
		int k;
		rd = 32'h0;
		for (k = 0; k < 200 && rd[7] !== 1'b1; k++)
			apb(1'b0, ADDR_CTRL, 32'h0);
		if (rd[7] !== 1'b1)
		begin
			bad_count++;
			finish_test();
		end
		rdc("status", ADDR_STAT, {24'h0, code});
	endtask : flag_is

	task automatic send(input logic [7:0] b, input logic exp);
		u_twi_master_model.xfer(b, 1'b1, rx, ack);
		check("ack", {31'h0, ack}, {31'h0, exp});
	endtask : send

	task automatic recv(input logic m_ack, input logic [7:0] exp);
		u_twi_master_model.xfer(8'hFF, m_ack, rx, ack);
		check("rx byte", {24'h0, rx}, {24'h0, exp});
	endtask : recv

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep_mode = 1'b0;
		lost_arb = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rdc("own", ADDR_OWN, 32'h0);
		rdc("status", ADDR_STAT, 32'hF8);
		rdc("data", ADDR_DATA, 32'hFF);
		apb(1'b0, 8'h1C, 32'h0);
		check("slverr", {31'h0, err}, 32'h1);
		$display("test reset done");
		wr(ADDR_OWN, 32'h53);
		wr(ADDR_CTRL, 32'h44);
		wr(ADDR_IEN, 32'h2);
		u_twi_master_model.start();
		send(8'h52, 1'b0);
		flag_is(SR_ADDR);
		wr(ADDR_CTRL, 32'h84);
		send(8'h3C, 1'b1);
		flag_is(SR_DATA_NACK);
		rdc("data", ADDR_DATA, 32'h3C);
		wr(ADDR_CTRL, 32'hC4);
		u_twi_master_model.stop();
		wr(ADDR_OWN, 32'h52);
		u_twi_master_model.start();
		send(8'h00, 1'b1);
		u_twi_master_model.stop();
		wr(ADDR_OWN, 32'h53);
		$display("test own write done");
		u_twi_master_model.start();
		send(8'h00, 1'b0);
		flag_is(SR_GC);
		wr(ADDR_CTRL, 32'hC4);
		send(8'h11, 1'b0);
		flag_is(SR_GC_ACK);
		wr(ADDR_CTRL, 32'h84);
		send(8'h22, 1'b1);
		flag_is(SR_GC_NACK);
		wr(ADDR_CTRL, 32'h84);
		u_twi_master_model.stop();
		u_twi_master_model.start();
		send(8'h52, 1'b1);
		u_twi_master_model.stop();
		wr(ADDR_CTRL, 32'h44);
		u_twi_master_model.start();
		send(8'h52, 1'b0);
		flag_is(SR_ADDR);
		wr(ADDR_CTRL, 32'hC4);
		u_twi_master_model.start();
		flag_is(SR_STOP);
		wr(ADDR_CTRL, 32'hC4);
		send(8'h52, 1'b0);
		flag_is(SR_ADDR);
		wr(ADDR_CTRL, 32'hC4);
		u_twi_master_model.stop();
		flag_is(SR_STOP);
		rdc("istat", ADDR_ISTAT, 32'h3);
		check("irq", {31'h0, irq}, 32'h1);
		wr(ADDR_IEN, 32'h0);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(ADDR_IEN, 32'h2);
		wr(ADDR_ICLR, 32'h2);
		check("irq cleared", {31'h0, irq}, 32'h0);
		$display("test general call done");
		wr(ADDR_CTRL, 32'hE4);
		for (n = 0; n < 200 && sda_oe !== 1'b1; n++)
			@(negedge clk_sys);
		if (n >= 200)
		begin
			bad_count++;
			finish_test();
		end
		check("start", {30'h0, sda_oe, scl}, 32'h3);
		repeat (100) @(posedge clk_sys);
		check("start end", {31'h0, sda_oe}, 32'h0);
		$display("test begin request done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk_sys);
			lost_arb <= k[0];
			u_twi_master_model.start();
			send(8'h53, 1'b0);
			flag_is(k[0] ? ST_ADDR_AL : ST_ADDR);
			wr(ADDR_DATA, {24'h0, 8'hA5 ^ {8{k[0]}}});
			wr(ADDR_CTRL, 32'h84);
			recv(k[0], 8'hA5 ^ {8{k[0]}});
			flag_is(k[0] ? ST_NACK : ST_LAST);
			wr(ADDR_CTRL, 32'hC4);
			recv(1'b1, 8'hFF);
			u_twi_master_model.stop();
		end
		@(posedge clk_sys);
		lost_arb <= 1'b0;
		$display("test transmit done");
		sleep_mode <= 1'b1;
		u_twi_master_model.start();
		send(8'h52, 1'b0);
		flag_is(SR_ADDR);
		check("wake", {30'h0, wake_req, scl_oe}, 32'h3);
		wr(ADDR_CTRL, 32'hC4);
		check("wake clear", {30'h0, wake_req, scl_oe}, 32'h0);
		send(8'h66, 1'b0);
		flag_is(SR_DATA_ACK);
		rdc("data kept", ADDR_DATA, 32'h5A);
		wr(ADDR_CTRL, 32'hC4);
		@(posedge clk_sys);
		sleep_mode <= 1'b0;
		u_twi_master_model.stop();
		flag_is(SR_STOP);
		rdc("istat wake", ADDR_ISTAT, 32'h7);
		wr(ADDR_CTRL, 32'hC4);
		check("drive", {30'h0, scl_out, sda_out}, 32'h0);
		check("stretch waits", stuck, 32'h0);
		$display("test sleep done");
		finish_test();
	end
endmodule : tb_two_wire_slave
`default_nettype wire
